/* shared/rotary_pkg.sv */
// constants and types shared by the rotary decoder design files
package rotary_pkg;
  // state machine one-hot codes, state Sn matches input pair n
  typedef enum logic [3:0] {
    ST_S0 = 4'h1,
    ST_S1 = 4'h2,
    ST_S2 = 4'h4,
    ST_S3 = 4'h8
  } rot_state_e;
  // decode modes
  localparam logic MODE_BINARY = 1'b0;
  localparam logic MODE_GRAY = 1'b1;
  // widths
  localparam int CNT_W = 16;
  localparam int FILT_W = 8;
  // reset values and the modulo that selects free roll-over
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] MOD_FREE = 16'h0000;
  localparam logic [1:0] PAIR_RESET = 2'h0;
  localparam logic [7:0] FILT_RESET = 8'h00;
endpackage

/* logic/input_filter.sv */
// digital glitch filter for one sensor input
`timescale 1ns/100ps
`default_nettype none
module input_filter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // filter setting in clock cycles
  input wire logic [7:0] filter_len,
  // raw and filtered level
  input wire logic raw_in,
  output logic filt_out
);
  logic filt_reg; // level passed on
  logic [7:0] cnt_reg; // cycles the raw level has differed and held
  logic differs; // raw level not yet accepted
  logic held_long; // raw level stable long enough
  assign differs = raw_in != filt_reg;
  assign held_long = cnt_reg >= filter_len;
  assign filt_out = filt_reg;
  // count stable cycles of a new level, restart on any return
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_reg <= 1'b0;
      cnt_reg <= rotary_pkg::FILT_RESET;
    end else if (ce) begin
      if (!differs) begin
        cnt_reg <= rotary_pkg::FILT_RESET; // glitch gone, restart
      end else if (held_long) begin
        filt_reg <= raw_in; // new level accepted [RULE13]
        cnt_reg <= rotary_pkg::FILT_RESET;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* logic/mod_counter.sv */
// 16-bit event counter with modulo wrap and overflow pulse
`timescale 1ns/100ps
`default_nettype none
module mod_counter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic [15:0] modulo,
  input wire logic clear,
  input wire logic step,
  // result
  output logic [15:0] count,
  output logic wrap
);
  logic [15:0] count_reg; // present count
  logic wrap_reg; // one-cycle wrap pulse
  logic at_top; // next step wraps
  assign at_top = (modulo == rotary_pkg::MOD_FREE) ? (count_reg == 16'hFFFF)
                                                   : (count_reg == modulo);
  assign count = count_reg;
  assign wrap = wrap_reg;
  // step, wrap to zero at modulo or free roll-over
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= rotary_pkg::CNT_RESET;
      wrap_reg <= 1'b0;
    end else if (ce) begin
      wrap_reg <= 1'b0;
      if (clear) begin
        count_reg <= rotary_pkg::CNT_RESET;
      end else if (step) begin
        wrap_reg <= at_top; // [RULE14]
        count_reg <= at_top ? rotary_pkg::CNT_RESET : count_reg + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* logic/two_signal_rotary_decoder.sv */
// two-input rotary decoder: filter, state machine, counters and flags
// Contract
// RULE1: binary mode state equals input pair
// RULE2: binary forward steps pulse forward counter
// RULE3: binary backward steps pulse reverse counter
// RULE4: binary two-step jump: invalid event, hold
// RULE5: binary equal input: stay, no pulses
// RULE6: invalid event sets flag, interrupt if enabled
// RULE7: gray mode state equals input pair
// RULE8: gray forward steps pulse forward counter
// RULE9: gray backward steps pulse reverse counter
// RULE10: gray two-step jump: invalid event, hold
// RULE11: gray equal input: stay, no pulses
// RULE12: software picks gray or binary mode
// RULE13: inputs pass stability filter first
// RULE14: forward counter wraps at modulo, overflow flag
// RULE15: binary S3 with 10 goes S2 backward
`timescale 1ns/100ps
`default_nettype none
module two_signal_rotary_decoder (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // configuration
  input wire logic enable,
  input wire logic mode_gray,
  input wire logic [7:0] filter_len,
  input wire logic [15:0] forward_modulo,
  input wire logic invalid_state_irq_enable,
  // flag clears, one-cycle pulses
  input wire logic clear_invalid,
  input wire logic clear_overflow,
  // sensor contacts a and b
  input wire logic sensor_a,
  input wire logic sensor_b,
  // counters and status
  output logic [15:0] forward_count,
  output logic [15:0] reverse_count,
  output logic forward_pulse,
  output logic reverse_pulse,
  output logic invalid_event,
  output logic invalid_flag,
  output logic forward_overflow_flag,
  output logic irq,
  output logic [1:0] state_code
);
  // step kinds
  localparam logic [1:0] STEP_NONE = 2'h0;
  localparam logic [1:0] STEP_FWD = 2'h1;
  localparam logic [1:0] STEP_REV = 2'h2;
  localparam logic [1:0] STEP_BAD = 2'h3;

  // classify a move from present code to input code
  function automatic logic [1:0] classify(input logic gray, input logic [1:0] cur,
                                          input logic [1:0] nxt);
    logic [1:0] pos_c;
    logic [1:0] pos_n;
    logic [1:0] diff;
    // gray to position: high bit kept, low bit is the xor of both
    pos_c = gray ? {cur[1], cur[1] ^ cur[0]} : cur;
    pos_n = gray ? {nxt[1], nxt[1] ^ nxt[0]} : nxt;
    diff = pos_n - pos_c;
    case (diff)
      2'h0: classify = STEP_NONE;
      2'h1: classify = STEP_FWD;
      2'h3: classify = STEP_REV;
      default: classify = STEP_BAD;
    endcase
  endfunction

  // one-hot state to code
  function automatic logic [1:0] enc(input rotary_pkg::rot_state_e s);
    case (s)
      rotary_pkg::ST_S1: enc = 2'h1;
      rotary_pkg::ST_S2: enc = 2'h2;
      rotary_pkg::ST_S3: enc = 2'h3;
      default: enc = 2'h0;
    endcase
  endfunction

  // code to one-hot state
  function automatic rotary_pkg::rot_state_e dec(input logic [1:0] c);
    case (c)
      2'h1: dec = rotary_pkg::ST_S1;
      2'h2: dec = rotary_pkg::ST_S2;
      2'h3: dec = rotary_pkg::ST_S3;
      default: dec = rotary_pkg::ST_S0;
    endcase
  endfunction

  logic filt_a; // filtered contact a
  logic filt_b; // filtered contact b
  logic [1:0] pair; // filtered input pair {a,b}
  logic [1:0] cur_code; // code of present state
  logic [1:0] kind; // step classification
  logic go_fwd; // forward step this cycle
  logic go_rev; // backward step this cycle
  logic go_bad; // invalid jump this cycle
  logic fwd_wrap; // forward counter wrapped
  logic [15:0] fwd_cnt; // forward counter value
  logic [15:0] rev_cnt; // reverse counter value
  logic start; // first cycle after enable rises
  rotary_pkg::rot_state_e state_reg; // present state
  logic en_reg; // enable seen last cycle
  logic fwd_pulse_reg; // registered forward pulse
  logic rev_pulse_reg; // registered reverse pulse
  logic bad_reg; // registered invalid event
  logic inv_flag_reg; // sticky invalid flag
  logic ovf_flag_reg; // sticky overflow flag
  logic irq_reg; // interrupt output
  logic [15:0] fwd_out_reg; // forward count output copy
  logic [15:0] rev_out_reg; // reverse count output copy

  // input filters, one per contact [RULE13]
  input_filter filt_a_i (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .filter_len(filter_len),
    .raw_in(sensor_a),
    .filt_out(filt_a)
  );
  input_filter filt_b_i (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .filter_len(filter_len),
    .raw_in(sensor_b),
    .filt_out(filt_b)
  );

  assign pair = {filt_a, filt_b};
  assign cur_code = enc(state_reg);
  assign start = enable && !en_reg;
  // gray positions run 00,01,11,10 [RULE7] [RULE8] [RULE9] [RULE10] [RULE11]
  // binary positions run 00,01,10,11 [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
  // S3 to 10 is one step back, the binary order gives that [RULE15]
  assign kind = classify(mode_gray, cur_code, pair);
  assign go_fwd = enable && !start && (kind == STEP_FWD);
  assign go_rev = enable && !start && (kind == STEP_REV);
  assign go_bad = enable && !start && (kind == STEP_BAD);

  // forward counter with modulo [RULE14]
  mod_counter fwd_ctr_i (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .modulo(forward_modulo),
    .clear(1'b0),
    .step(go_fwd),
    .count(fwd_cnt),
    .wrap(fwd_wrap)
  );
  // reverse counter, free roll-over
  mod_counter rev_ctr_i (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .modulo(rotary_pkg::MOD_FREE),
    .clear(1'b0),
    .step(go_rev),
    .count(rev_cnt),
    .wrap()
  );

  // state register: follow valid steps, hold on invalid, sync on enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= rotary_pkg::ST_S0;
      en_reg <= 1'b0;
    end else if (ce) begin
      en_reg <= enable;
      if (start || go_fwd || go_rev) begin
        state_reg <= dec(pair); // [RULE2] [RULE3] [RULE8] [RULE9]
      end
    end
  end

  // event pulses and copies of the counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_pulse_reg <= 1'b0;
      rev_pulse_reg <= 1'b0;
      bad_reg <= 1'b0;
      fwd_out_reg <= rotary_pkg::CNT_RESET;
      rev_out_reg <= rotary_pkg::CNT_RESET;
    end else if (ce) begin
      fwd_pulse_reg <= go_fwd;
      rev_pulse_reg <= go_rev;
      bad_reg <= go_bad; // [RULE4] [RULE10]
      fwd_out_reg <= fwd_cnt;
      rev_out_reg <= rev_cnt;
    end
  end

  // sticky flags, a set beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inv_flag_reg <= 1'b0;
      ovf_flag_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (ce) begin
      inv_flag_reg <= go_bad || (inv_flag_reg && !clear_invalid); // [RULE6]
      ovf_flag_reg <= fwd_wrap || (ovf_flag_reg && !clear_overflow); // [RULE14]
      irq_reg <= invalid_state_irq_enable && (go_bad || (inv_flag_reg && !clear_invalid)); // [RULE6]
    end
  end

  assign forward_count = fwd_out_reg;
  assign reverse_count = rev_out_reg;
  assign forward_pulse = fwd_pulse_reg;
  assign reverse_pulse = rev_pulse_reg;
  assign invalid_event = bad_reg;
  assign invalid_flag = inv_flag_reg;
  assign forward_overflow_flag = ovf_flag_reg;
  assign irq = irq_reg;
  assign state_code = cur_code;
endmodule
`default_nettype wire

/* verif/rotary_disc.sv */
// disc contact model driving the two sensor lines
`timescale 1ns/100ps
`default_nettype none
module rotary_disc (
  // disc position as contact pair, a in bit 1
  input wire logic [1:0] pos,
  // contact outputs
  output logic sensor_a,
  output logic sensor_b
);
  // contacts follow the disc position directly, steps chosen by the bench
  assign sensor_a = pos[1];
  assign sensor_b = pos[0];
endmodule
`default_nettype wire

/* verif/rotary_checker_assertions.sv */
// concurrent checks on the rotary decoder ports
`timescale 1ns/100ps
`default_nettype none
module rotary_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched inputs
  input wire logic mode_gray,
  input wire logic invalid_state_irq_enable,
  input wire logic clear_invalid,
  // watched outputs
  input wire logic [15:0] forward_count,
  input wire logic [15:0] reverse_count,
  input wire logic forward_pulse,
  input wire logic reverse_pulse,
  input wire logic invalid_event,
  input wire logic invalid_flag,
  input wire logic forward_overflow_flag,
  input wire logic irq,
  input wire logic [1:0] state_code
);
  logic [1:0] prev_code; // state code one cycle back
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // remember the last state code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_code <= 2'h0;
    end else begin
      prev_code <= state_code;
    end
  end
  // overflow flag just set
  sequence ovf_set;
    $rose(forward_overflow_flag);
  endsequence
  a_fwd_bin_step: assert property (forward_pulse && !mode_gray |-> state_code == prev_code + 2'h1)
    else $error("binary forward step wrong");
  a_fwd_gray_step: assert property (forward_pulse && mode_gray |-> state_code == {prev_code[0], ~prev_code[1]})
    else $error("gray forward step wrong");
  a_rev_bin_step: assert property (reverse_pulse && !mode_gray |-> state_code == prev_code - 2'h1)
    else $error("binary backward step wrong");
  a_rev_gray_step: assert property (reverse_pulse && mode_gray |-> state_code == {~prev_code[0], prev_code[1]})
    else $error("gray backward step wrong");
  a_jump_holds_state: assert property (invalid_event |-> state_code == prev_code && !forward_pulse && !reverse_pulse)
    else $error("jump changed state or counted");
  a_fwd_count_adds: assert property (forward_pulse |=> forward_count == $past(forward_count) + 16'h1 || forward_count == 16'h0000)
    else $error("forward count not advanced");
  a_rev_count_adds: assert property (reverse_pulse |=> reverse_count == $past(reverse_count) + 16'h1)
    else $error("reverse count not advanced");
  a_idle_counts_hold: assert property (!forward_pulse && !reverse_pulse |=> $stable(forward_count) && $stable(reverse_count))
    else $error("count moved without pulse");
  a_jump_sets_flag: assert property (invalid_event |-> invalid_flag)
    else $error("invalid flag not set");
  a_flag_sticky: assert property (invalid_flag && !clear_invalid |=> invalid_flag)
    else $error("invalid flag lost");
  a_irq_gated: assert property (irq == ($past(invalid_state_irq_enable) && invalid_flag))
    else $error("irq not gated by enable");
  a_ovf_at_zero: assert property (ovf_set |-> forward_count == 16'h0000)
    else $error("overflow without wrap to zero");
endmodule
bind two_signal_rotary_decoder rotary_checker u_chk (.clk, .rst_n, .mode_gray,
  .invalid_state_irq_enable, .clear_invalid, .forward_count, .reverse_count, .forward_pulse,
  .reverse_pulse, .invalid_event, .invalid_flag, .forward_overflow_flag, .irq, .state_code);
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the two-input rotary decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, want) begin total_checks++; if ((got) !== (want)) begin miscompares++; \
  $display("[FAIL] %0t got %0h want %0h", $time, got, want); end end
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, enable = 1'b0, mode_gray = 1'b0, irq_en = 1'b0;
  logic clr_inv = 1'b0, clr_ovf = 1'b0;
  logic [7:0] filter_len = 8'h00;
  logic [15:0] modulo = 16'h0000, fwd_exp = 16'h0000, rev_exp = 16'h0000;
  logic [1:0] pos = 2'h0, s, n, code; // disc position, row start, row next, outcome
  wire sensor_a, sensor_b;
  logic [15:0] forward_count, reverse_count;
  logic forward_pulse, reverse_pulse, invalid_event, invalid_flag, ovf_flag, irq;
  logic [1:0] state_code;
  int miscompares = 0, total_checks = 0;
  // outcome per binary then gray start state, two bits per next pair: 0 hold 1 fwd 2 rev 3 jump
  localparam logic [7:0] rows [8] = '{8'hB4, 8'hD2, 8'h4B, 8'h2D, 8'hE4, 8'h72, 8'h8D, 8'h1B};
  // 100 ns clock
  always #50 clk = ~clk;
  rotary_disc disc (.pos(pos), .sensor_a(sensor_a), .sensor_b(sensor_b));
  two_signal_rotary_decoder dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .enable(enable),
    .mode_gray(mode_gray), .filter_len(filter_len), .forward_modulo(modulo),
    .invalid_state_irq_enable(irq_en), .clear_invalid(clr_inv), .clear_overflow(clr_ovf),
    .sensor_a(sensor_a), .sensor_b(sensor_b), .forward_count(forward_count),
    .reverse_count(reverse_count), .forward_pulse(forward_pulse), .reverse_pulse(reverse_pulse),
    .invalid_event(invalid_event), .invalid_flag(invalid_flag),
    .forward_overflow_flag(ovf_flag), .irq(irq), .state_code(state_code));
  // wait k falling edges
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // decoder off, move disc, decoder on so the state syncs without a pulse
  task sync(input logic [1:0] p);
    enable = 1'b0;
    pos = p;
    cyc(5);
    enable = 1'b1;
    cyc(2);
  endtask
  // verdict and end of run
  task close_out;
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // cut a hang short
  initial begin
    #200000;
    miscompares++;
    close_out();
  end
  // main sequence
  initial begin
    cyc(6);
    rst_n = 1'b1;
    cyc(1);
    // every mode, start state and next pair
    for (int r = 0; r < 32; r++) begin
      mode_gray = r[4];
      irq_en = r[4];
      s = r[3:2];
      n = r[1:0];
      code = rows[r >> 2][{n, 1'b0} +: 2];
      sync(s);
      pos = n;
      cyc(4);
      if (code == 2'h1) fwd_exp++;
      if (code == 2'h2) rev_exp++;
      `CHK(state_code, (code == 2'h1 || code == 2'h2) ? n : s)
      `CHK(forward_count, fwd_exp)
      `CHK(reverse_count, rev_exp)
      `CHK(invalid_flag, code == 2'h3)
      `CHK(irq, code == 2'h3 && r[4])
      enable = 1'b0;
      clr_inv = 1'b1;
      cyc(1);
      clr_inv = 1'b0;
      cyc(1);
    end
    // back-to-back forward steps across a modulo of ten
    enable = 1'b0;
    mode_gray = 1'b0;
    modulo = 16'h000A;
    sync(2'h0);
    for (int k = 1; k < 4; k++) begin
      pos = k[1:0];
      cyc(1);
    end
    cyc(4);
    `CHK(forward_count, 16'h0000)
    `CHK(ovf_flag, 1'b1)
    clr_ovf = 1'b1;
    cyc(1);
    clr_ovf = 1'b0;
    cyc(1);
    `CHK(ovf_flag, 1'b0)
    // a two-cycle glitch is filtered, a held level passes
    enable = 1'b0;
    filter_len = 8'h03;
    modulo = 16'h0000;
    sync(2'h3);
    pos = 2'h0;
    cyc(2);
    pos = 2'h3;
    cyc(8);
    `CHK(forward_count, 16'h0000)
    pos = 2'h0;
    cyc(10);
    `CHK(forward_count, 16'h0001)
    // reset in mid-run clears counts and state
    rst_n = 1'b0;
    cyc(2);
    `CHK(reverse_count, 16'h0000)
    `CHK(forward_count, 16'h0000)
    `CHK(state_code, 2'h0)
    rst_n = 1'b1;
    cyc(2);
    close_out();
  end
endmodule
`default_nettype wire
